// ---- hw/init_filter_pkg.sv ----
// Purpose: shared constants and carriers for the init-block loader and address filter
// Assumes: 16-bit host memory words, APB register access with 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each
package init_filter_pkg;

    // ------------------------------------------------------------
    // init block layout, word index = byte offset / 2
    // ------------------------------------------------------------
    localparam int unsigned IB_WORDS        = 12;
    localparam logic [3:0]  IB_W_MODE       = 4'h0;
    localparam logic [3:0]  IB_W_NODE0      = 4'h1;
    localparam logic [3:0]  IB_W_NODE2      = 4'h3;
    localparam logic [3:0]  IB_W_FILT0      = 4'h4;
    localparam logic [3:0]  IB_W_FILT3      = 4'h7;
    localparam logic [3:0]  IB_W_RX_BASE_LO = 4'h8;
    localparam logic [3:0]  IB_W_RX_BASE_HI = 4'h9;
    localparam logic [3:0]  IB_W_TX_BASE_LO = 4'hA;
    localparam logic [3:0]  IB_W_TX_BASE_HI = 4'hB;
    localparam int unsigned LEN_CODE_MSB    = 15;
    localparam int unsigned LEN_CODE_LSB    = 13;
    localparam int unsigned BASE_HI_MSB     = 7;

    // ------------------------------------------------------------
    // mode control word fields
    // ------------------------------------------------------------
    localparam int unsigned MODE_PROMISC    = 15;
    localparam int unsigned MODE_BCAST_DIS  = 14;
    localparam int unsigned MODE_TX_FCS_DIS = 3;
    localparam logic [15:0] MODE_RST        = 16'h0000;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam logic [7:0]  REG_INIT_BASE   = 8'h08;
    localparam logic [7:0]  REG_MODE        = 8'h0C;
    localparam logic [7:0]  REG_RX_LEN      = 8'h10;
    localparam logic [7:0]  REG_TX_LEN      = 8'h14;
    localparam logic [7:0]  REG_FILT_RESULT = 8'h18;
    localparam int unsigned CTRL_START      = 0;
    localparam logic [23:0] INIT_BASE_RST   = 24'h00_0000;
    localparam logic [15:0] RING_LEN_RST    = 16'h0000;

    // ------------------------------------------------------------
    // frame check sequence
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_POLY_REFL   = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT        = 32'hFFFF_FFFF;
    localparam int unsigned ADDR_BYTES      = 6;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] base;
        logic [15:0] entries;
    } ring_cfg_s;

    typedef struct packed {
        logic       accept;
        logic       broadcast;
        logic       logical;
        logic       node_match;
        logic       hash_hit;
        logic [5:0] hash_index;
    } filt_result_s;

    typedef enum logic [1:0] {
        LD_IDLE  = 2'b00,
        LD_REQ   = 2'b01,
        LD_WAIT  = 2'b10
    } load_state_e;

endpackage

// ---- hw/crc32_byte_step.sv ----
// Purpose: one byte step of the frame check sequence, least significant bit first
// Assumes: reflected generator, running value kept by the caller
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module crc32_byte_step
    import init_filter_pkg::*;
(
    // running value in
    input  wire logic [31:0] crc_i,
    input  wire logic [7:0]  byte_i,
    // next value out
    output logic      [31:0] crc_o
);

    always_comb begin
        logic [31:0] c;
        c = crc_i;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ byte_i[i]) begin
                c = (c >> 1) ^ CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        crc_o = c;
    end

endmodule
`default_nettype wire

// ---- hw/init_block_address_filter.sv ----
// Purpose: fetch the initialization block from host memory and filter receive addresses
// Assumes: memory read port and receive byte stream are on clk_sys_i
// Notes:   APB slave answers with zero wait states
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none

module init_block_address_filter
    import init_filter_pkg::*;
#(
    parameter int unsigned ADDR_W = 24
)(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // host memory read port
    output logic                   mem_req_o,
    output logic      [ADDR_W-1:0] mem_addr_o,
    input  wire logic              mem_ack_i,
    input  wire logic [15:0]       mem_rdata_i,
    // receive destination byte stream
    input  wire logic              rx_byte_valid_i,
    input  wire logic              rx_addr_start_i,
    input  wire logic [7:0]        rx_byte_i,
    // loaded configuration
    output logic                   init_done_o,
    output logic      [15:0]       mode_control_reg_o,
    output logic      [47:0]       node_physical_address_o,
    output logic      [63:0]       multicast_hash_filter_o,
    output ring_cfg_s              rx_ring_o,
    output ring_cfg_s              tx_ring_o,
    // filter verdict
    output logic                   filt_done_o,
    output filt_result_s           filt_result_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    load_state_e  state_ff;
    logic [3:0]   word_idx_ff;
    logic [23:0]  init_block_base_ff;
    logic         init_done_ff;
    logic [15:0]  mode_ff;
    logic [47:0]  node_ff;
    logic [63:0]  filter_ff;
    logic [23:0]  rx_base_ff;
    logic [23:0]  tx_base_ff;
    logic [2:0]   rx_ring_length_code_ff;
    logic [2:0]   tx_ring_length_code_ff;
    logic [15:0]  rx_ring_length_reg_ff;
    logic [15:0]  tx_ring_length_reg_ff;
    logic         rx_len_ovr_ff;
    logic         tx_len_ovr_ff;
    logic [31:0]  crc_ff;
    logic [2:0]   byte_cnt_ff;
    logic         logical_ff;
    logic         bcast_ff;
    logic         match_ff;
    logic         filt_done_ff;
    filt_result_s filt_result_ff;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire apb_acc   = psel_i & penable_i;
    wire apb_wr    = apb_acc & pwrite_i;
    wire sel_ctrl  = (paddr_i == REG_CTRL);
    wire sel_stat  = (paddr_i == REG_STATUS);
    wire sel_base  = (paddr_i == REG_INIT_BASE);
    wire sel_mode  = (paddr_i == REG_MODE);
    wire sel_rxl   = (paddr_i == REG_RX_LEN);
    wire sel_txl   = (paddr_i == REG_TX_LEN);
    wire sel_filt  = (paddr_i == REG_FILT_RESULT);
    wire sel_any   = sel_ctrl | sel_stat | sel_base | sel_mode | sel_rxl | sel_txl | sel_filt;
    wire busy      = (state_ff != LD_IDLE);
    wire start     = apb_wr & sel_ctrl & pwdata_i[CTRL_START] & ~busy;
    // length registers only count once the block has been loaded
    wire wr_rxl    = apb_wr & sel_rxl & init_done_ff & ~busy;
    wire wr_txl    = apb_wr & sel_txl & init_done_ff & ~busy;

    assign pready_o  = 1'b1;
    assign pslverr_o = apb_acc & ~sel_any;

    always_comb begin
        prdata_o = 32'h0000_0000;
        if (apb_acc & ~pwrite_i) begin
            if (sel_stat) begin
                prdata_o[3:0] = {tx_len_ovr_ff, rx_len_ovr_ff, init_done_ff, busy};
            end else if (sel_base) begin
                prdata_o[23:0] = init_block_base_ff;
            end else if (sel_mode) begin
                prdata_o[15:0] = mode_ff;
            end else if (sel_rxl) begin
                prdata_o[15:0] = rx_ring_o.entries;
            end else if (sel_txl) begin
                prdata_o[15:0] = tx_ring_o.entries;
            end else if (sel_filt) begin
                prdata_o[$bits(filt_result_s)-1:0] = filt_result_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // init block fetch
    // ------------------------------------------------------------
    // bit 0 of the base is dropped so every fetch stays word aligned
    wire [23:0] aligned_base = {init_block_base_ff[23:1], 1'b0};
    wire [23:0] word_addr    = aligned_base + {19'h0_0000, word_idx_ff, 1'b0};
    wire        word_taken   = (state_ff == LD_WAIT) & mem_ack_i;
    wire        last_word    = (word_idx_ff == 4'(IB_WORDS - 1));

    assign mem_req_o  = (state_ff == LD_REQ) | (state_ff == LD_WAIT);
    assign mem_addr_o = ADDR_W'(word_addr);

    load_state_e nxt_state;
    always_comb begin
        case (state_ff)
            LD_IDLE: nxt_state = start ? LD_REQ : LD_IDLE;
            LD_REQ:  nxt_state = LD_WAIT;
            LD_WAIT: nxt_state = word_taken ? (last_word ? LD_IDLE : LD_REQ) : LD_WAIT;
            default: nxt_state = LD_IDLE;
        endcase
    end

    wire [3:0] nxt_word_idx = start ? 4'h0 : (word_taken ? word_idx_ff + 4'h1 : word_idx_ff);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= LD_IDLE;
            word_idx_ff <= 4'h0;
        end else begin
            state_ff    <= nxt_state;
            word_idx_ff <= nxt_word_idx;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_done_ff <= 1'b0;
        end else if (start) begin
            init_done_ff <= 1'b0;
        end else if (word_taken & last_word) begin
            init_done_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_block_base_ff <= INIT_BASE_RST;
        end else if (apb_wr & sel_base & ~busy) begin
            init_block_base_ff <= pwdata_i[23:0];
        end
    end

    // the fetched word wins over a software write in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_ff <= MODE_RST;
        end else if (word_taken & (word_idx_ff == IB_W_MODE)) begin
            mode_ff <= mem_rdata_i;
        end else if (apb_wr & sel_mode) begin
            mode_ff <= pwdata_i[15:0];
        end
    end

    // node address and filter words arrive low word first
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            node_ff   <= 48'h0000_0000_0000;
            filter_ff <= 64'h0000_0000_0000_0000;
        end else if (word_taken) begin
            if (word_idx_ff >= IB_W_NODE0 && word_idx_ff <= IB_W_NODE2) begin
                node_ff[(word_idx_ff - IB_W_NODE0)*16 +: 16] <= mem_rdata_i;
            end
            if (word_idx_ff >= IB_W_FILT0 && word_idx_ff <= IB_W_FILT3) begin
                filter_ff[(word_idx_ff - IB_W_FILT0)*16 +: 16] <= mem_rdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_base_ff             <= 24'h00_0000;
            tx_base_ff             <= 24'h00_0000;
            rx_ring_length_code_ff <= 3'h0;
            tx_ring_length_code_ff <= 3'h0;
        end else if (word_taken) begin
            case (word_idx_ff)
                IB_W_RX_BASE_LO: rx_base_ff[15:0] <= mem_rdata_i;
                IB_W_TX_BASE_LO: tx_base_ff[15:0] <= mem_rdata_i;
                IB_W_RX_BASE_HI: begin
                    rx_base_ff[23:16]      <= mem_rdata_i[BASE_HI_MSB:0];
                    rx_ring_length_code_ff <= mem_rdata_i[LEN_CODE_MSB:LEN_CODE_LSB];
                end
                IB_W_TX_BASE_HI: begin
                    tx_base_ff[23:16]      <= mem_rdata_i[BASE_HI_MSB:0];
                    tx_ring_length_code_ff <= mem_rdata_i[LEN_CODE_MSB:LEN_CODE_LSB];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // ring length override
    // ------------------------------------------------------------
    // a fresh init drops any override so the loaded codes apply again
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_ring_length_reg_ff <= RING_LEN_RST;
            tx_ring_length_reg_ff <= RING_LEN_RST;
            rx_len_ovr_ff         <= 1'b0;
            tx_len_ovr_ff         <= 1'b0;
        end else begin
            if (start) begin
                rx_len_ovr_ff <= 1'b0;
                tx_len_ovr_ff <= 1'b0;
            end
            if (wr_rxl) begin
                rx_ring_length_reg_ff <= pwdata_i[15:0];
                rx_len_ovr_ff         <= 1'b1;
            end
            if (wr_txl) begin
                tx_ring_length_reg_ff <= pwdata_i[15:0];
                tx_len_ovr_ff         <= 1'b1;
            end
        end
    end

    wire [15:0] rx_decoded = 16'h0001 << rx_ring_length_code_ff;
    wire [15:0] tx_decoded = 16'h0001 << tx_ring_length_code_ff;

    // bases pass through untouched; 8-byte entry alignment is up to the host
    assign rx_ring_o.base    = rx_base_ff;
    assign tx_ring_o.base    = tx_base_ff;
    assign rx_ring_o.entries = rx_len_ovr_ff ? rx_ring_length_reg_ff : rx_decoded;
    assign tx_ring_o.entries = tx_len_ovr_ff ? tx_ring_length_reg_ff : tx_decoded;

    assign init_done_o             = init_done_ff;
    assign mode_control_reg_o      = mode_ff;
    assign node_physical_address_o = node_ff;
    assign multicast_hash_filter_o = filter_ff;

    // ------------------------------------------------------------
    // destination address filter
    // ------------------------------------------------------------
    wire        first_byte = rx_byte_valid_i & rx_addr_start_i;
    wire        in_addr    = rx_byte_valid_i & (rx_addr_start_i | (byte_cnt_ff != 3'h0));
    wire [31:0] crc_seed   = rx_addr_start_i ? CRC_INIT : crc_ff;
    wire [2:0]  byte_k     = rx_addr_start_i ? 3'h0 : byte_cnt_ff;
    wire [31:0] crc_next;
    // byte k of the address is compared with node bits 8k+7 down to 8k
    wire        byte_match = (rx_byte_i == node_ff[byte_k*8 +: 8]);
    wire        last_byte  = in_addr & (byte_k == 3'(ADDR_BYTES - 1));

    crc32_byte_step u_crc_step (
        .crc_i  (crc_seed),
        .byte_i (rx_byte_i),
        .crc_o  (crc_next)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_ff      <= CRC_INIT;
            byte_cnt_ff <= 3'h0;
            logical_ff  <= 1'b0;
            bcast_ff    <= 1'b0;
            match_ff    <= 1'b0;
        end else if (in_addr) begin
            crc_ff      <= crc_next;
            byte_cnt_ff <= last_byte ? 3'h0 : byte_k + 3'h1;
            // bit 0 of the first byte is the first bit on the wire
            logical_ff  <= first_byte ? rx_byte_i[0] : logical_ff;
            bcast_ff    <= (first_byte | bcast_ff) & (rx_byte_i == 8'hFF);
            match_ff    <= (first_byte | match_ff) & byte_match;
        end
    end

    // verdict on the last address byte, using the values it completes
    wire       v_logical = (byte_k == 3'h0) ? rx_byte_i[0] : logical_ff;
    wire       v_bcast   = bcast_ff & (rx_byte_i == 8'hFF);
    wire       v_match   = match_ff & byte_match;
    wire [5:0] v_index   = crc_next[31:26];
    wire       v_hit     = filter_ff[v_index];
    wire       promisc   = mode_ff[MODE_PROMISC];
    wire       bc_dis    = mode_ff[MODE_BCAST_DIS];

    filt_result_s nxt_result;
    always_comb begin
        nxt_result            = '0;
        nxt_result.broadcast  = v_bcast;
        nxt_result.logical    = v_logical;
        nxt_result.node_match = v_match & ~v_logical;
        nxt_result.hash_hit   = v_hit & v_logical & ~v_bcast;
        nxt_result.hash_index = v_index;
        if (v_bcast) begin
            nxt_result.accept = ~bc_dis | promisc;
        end else if (v_logical) begin
            nxt_result.accept = v_hit | promisc;
        end else begin
            nxt_result.accept = v_match | promisc;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_done_ff   <= 1'b0;
            filt_result_ff <= '0;
        end else begin
            filt_done_ff <= last_byte;
            if (last_byte) begin
                filt_result_ff <= nxt_result;
            end
        end
    end

    assign filt_done_o   = filt_done_ff;
    assign filt_result_o = filt_result_ff;

endmodule
`default_nettype wire

// ---- tb/init_filter_assertions.sv ----
// Purpose: port-level checks of the init block loader and the address filter
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module init_filter_assertions
    import init_filter_pkg::*;
#(
    parameter int unsigned ADDR_W = 24
)(
    // clock and reset
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    // memory port
    input wire logic              mem_req_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              mem_ack_i,
    // loaded configuration and verdict
    input wire logic              init_done_o,
    input wire logic [15:0]       mode_control_reg_o,
    input wire logic [63:0]       multicast_hash_filter_o,
    input wire ring_cfg_s         rx_ring_o,
    input wire ring_cfg_s         tx_ring_o,
    input wire logic              filt_done_o,
    input wire filt_result_s      filt_result_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    wire logic prom = mode_control_reg_o[MODE_PROMISC];
    wire logic bdis = mode_control_reg_o[MODE_BCAST_DIS];
    wire logic lg   = filt_done_o && filt_result_o.logical && !filt_result_o.broadcast;

    property p_base_even; mem_req_o |-> mem_addr_o[0] == 1'b0; endproperty
    a_base_even: assert property (p_base_even) else $error("odd fetch address");
    property p_addr_hold; mem_req_o && !mem_ack_i |=> !mem_req_o || $stable(mem_addr_o); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
    property p_load_end; $rose(init_done_o) |-> !mem_req_o; endproperty
    a_load_end: assert property (p_load_end) else $error("fetch after load end");
    property p_len_pow2;
        $rose(init_done_o) |-> $onehot(rx_ring_o.entries) && $onehot(tx_ring_o.entries)
            && rx_ring_o.entries <= 16'h0080 && tx_ring_o.entries <= 16'h0080;
    endproperty
    a_len_pow2: assert property (p_len_pow2) else $error("ring size not decoded");
    property p_hash; lg |-> filt_result_o.hash_hit == multicast_hash_filter_o[filt_result_o.hash_index];
    endproperty
    a_hash: assert property (p_hash) else $error("hash bit mismatch");
    property p_zero_filt; lg && multicast_hash_filter_o == 64'h0 && !prom |-> !filt_result_o.accept;
    endproperty
    a_zero_filt: assert property (p_zero_filt) else $error("empty filter accepted");
    property p_bc_on; filt_done_o && filt_result_o.broadcast && !bdis |-> filt_result_o.accept;
    endproperty
    a_bc_on: assert property (p_bc_on) else $error("broadcast rejected");
    property p_bc_off; filt_done_o && filt_result_o.broadcast && bdis |-> filt_result_o.accept == prom;
    endproperty
    a_bc_off: assert property (p_bc_off) else $error("disabled broadcast wrong");
    property p_phys;
        filt_done_o && !filt_result_o.logical |-> filt_result_o.accept == (filt_result_o.node_match || prom);
    endproperty
    a_phys: assert property (p_phys) else $error("physical verdict wrong");
endmodule
bind init_block_address_filter init_filter_assertions #(.ADDR_W(ADDR_W)) init_filter_assertions_inst (
    .clk_sys_i, .rst_n_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .init_done_o, .mode_control_reg_o,
    .multicast_hash_filter_o, .rx_ring_o, .tx_ring_o, .filt_done_o, .filt_result_o);
`default_nettype wire

// ---- tb/host_mem_model.sv ----
// Purpose: host memory holding the init block, answering word fetches
// Assumes: word index taken from address bits 8:1
// Notes:   answer delay varies from one to four cycles after the request is seen
`timescale 1ns/10ps
`default_nettype none
module host_mem_model #(
    parameter int unsigned ADDR_W = 24
)(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              mem_req_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    output logic                   mem_ack_o,
    output logic      [15:0]       mem_rdata_o
);
    logic [15:0] mem [0:255];
    logic [15:0] word_ff;
    logic [2:0]  wait_ff;
    logic [2:0]  delay_ff;
    // released bus never shows the last word, so a late sample cannot pass
    assign mem_rdata_o = mem_ack_o ? word_ff : ~word_ff;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ack_o <= 1'b0;
            wait_ff   <= 3'h0;
            delay_ff  <= 3'h1;
            word_ff   <= 16'h0000;
        end else if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            wait_ff   <= 3'h0;
            delay_ff  <= 3'($urandom_range(1, 4));
        end else if (mem_req_i) begin
            if (wait_ff >= delay_ff) begin
                mem_ack_o <= 1'b1;
                word_ff   <= mem[mem_addr_i[8:1]];
            end else begin
                wait_ff <= wait_ff + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the init block loader and address filter
// Assumes: zero wait APB slave, host memory model on the fetch port
// Notes:   verdicts and read data are queued by the drivers and checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import init_filter_pkg::*;
    logic clk = 1'b0, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_ack;
    logic init_done, filt_done, rxv, rxs;
    logic [7:0] paddr, rxb;
    logic [31:0] pwdata, prdata;
    logic [23:0] mem_addr, base;
    logic [15:0] mem_rdata, mode;
    logic [47:0] node, nd;
    logic [63:0] filt;
    logic [33:0] e;
    logic [15:0] tm;
    logic [63:0] tf;
    logic [5:0] hx;
    ring_cfg_s rxr, txr;
    filt_result_s fres;
    logic [33:0] rdq[$];
    logic fq[$];
    int errors = 0, check_count = 0;

    always #25 clk = ~clk;

    init_block_address_filter init_block_address_filter_inst (.clk_sys_i(clk), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mem_req),
        .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .rx_byte_valid_i(rxv),
        .rx_addr_start_i(rxs), .rx_byte_i(rxb), .init_done_o(init_done), .mode_control_reg_o(mode),
        .node_physical_address_o(node), .multicast_hash_filter_o(filt), .rx_ring_o(rxr),
        .tx_ring_o(txr), .filt_done_o(filt_done), .filt_result_o(fres));
    host_mem_model host_mem_model_inst (.clk_sys_i(clk), .rst_n_i(rst_n), .mem_req_i(mem_req),
        .mem_addr_i(mem_addr), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // exp holds {compare data, error flag, data}; only reads are queued
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] exp);
        int n;
        if (!wr) rdq.push_back(exp);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin errors++; close_out(); end
        // one idle edge keeps a following call from driving psel twice in a step
        @(posedge clk);
    endtask

    function automatic logic want(input logic [47:0] a, input logic [15:0] m);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++) c = (c[0] ^ a[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
        hx = c[31:26];
        if (&a) return !m[MODE_BCAST_DIS] || m[MODE_PROMISC];
        if (a[0]) return tf[c[31:26]] || m[MODE_PROMISC];
        return a == nd || m[MODE_PROMISC];
    endfunction

    task automatic send(input logic [47:0] a);
        fq.push_back(want(a, tm));
        for (int k = 0; k < 6; k++) begin
            rxv <= 1'b1; rxs <= (k == 0); rxb <= a[8*k +: 8];
            @(posedge clk);
        end
        rxv <= 1'b0; rxs <= 1'b0; rxb <= 8'($urandom);
        repeat (3) @(posedge clk);
    endtask

    task automatic load(input logic [15:0] m, input logic [63:0] f);
        logic [15:0] w [0:11];
        int n;
        base = {18'h0, 3'($urandom_range(0, 7)), 3'h0};
        tm = m;
        tf = f;
        w = '{m, nd[15:0], nd[31:16], nd[47:32], f[15:0], f[31:16], f[47:32], f[63:48],
              16'h1238, 16'h6012, 16'h5670, 16'hE034};
        for (int i = 0; i < 12; i++) host_mem_model_inst.mem[base[8:1] + i] = w[i];
        apb(1'b1, REG_INIT_BASE, {8'h0, base}, 34'h0);
        apb(1'b1, REG_CTRL, 32'h0000_0001, 34'h0);
        n = 0;
        while (init_done !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        if (n >= 300) begin errors++; close_out(); end
        check(node, nd, "node address");
        check(filt, f, "hash filter");
        check(mode, m, "mode word");
        check(rxr, {24'h12_1238, 16'h0008}, "rx ring");
        check(txr, {24'h34_5670, 16'h0080}, "tx ring");
        apb(1'b0, REG_STATUS, 0, 34'h2_0000_0002);
    endtask

    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            e = rdq.pop_front();
            check(pslverr, e[32], "apb error flag");
            if (e[33]) check(prdata, e[31:0], "apb read data");
        end
        if (filt_done === 1'b1) check(fres.accept, fq.pop_front(), "filter verdict");
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; rxv = 1'b0; rxs = 1'b0; rxb = 8'h00;
        void'($urandom(32'h5f75));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_STATUS, 0, 34'h2_0000_0000);
        apb(1'b0, REG_RX_LEN, 0, 34'h2_0000_0001);
        apb(1'b0, 8'h1C, 0, 34'h1_0000_0000);
        $display("test reset done");
        nd = {$urandom, 16'($urandom)} & 48'hFFFF_FFFF_FFFE;
        load(16'h0008, {$urandom, $urandom});
        apb(1'b1, REG_RX_LEN, 32'h0000_0005, 34'h0);
        apb(1'b0, REG_RX_LEN, 0, 34'h2_0000_0005);
        apb(1'b0, REG_TX_LEN, 0, 34'h2_0000_0080);
        $display("test load done");
        for (int mi = 0; mi < 4; mi++) begin
            apb(1'b1, REG_MODE, 32'(mi) << 14, 34'h0);
            tm = 16'(mi << 14);
            send(48'hFFFF_FFFF_FFFF);
            send(nd);
            send(nd ^ 48'h00_0000_0100);
            repeat (4) send({$urandom, 16'($urandom)} | 48'h1);
        end
        $display("test filter done");
        load(16'h0000, 64'h0);
        repeat (6) send({$urandom, 16'($urandom)} | 48'h1);
        send(nd);
        apb(1'b0, REG_FILT_RESULT, 0, {2'h2, 21'h00_0000, 5'h12, hx});
        $display("test empty filter done");
        close_out();
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
